/* common/uhede_pkg.sv */
// package with the register map, descriptor layout, codes and carrier types of the descriptor engine
package uhede_pkg;
    // ----------------------------------------------------------------
    // register byte offsets on the apb side
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_LIST_HEAD = 8'h04;
    localparam logic [7:0] REG_STATE = 8'h08;
    localparam logic [7:0] REG_INT_STATUS = 8'h0C;
    localparam logic [7:0] REG_INT_ENABLE = 8'h10;
    localparam logic [7:0] REG_INT_CLEAR = 8'h14;
    localparam logic [7:0] REG_CUR_ED = 8'h18;
    localparam logic [31:0] RST_LIST_HEAD = 32'h0000_0000;
    localparam logic [3:0] RST_INT_ENABLE = 4'h0;
    localparam int CTRL_START_BIT = 0;
    // ----------------------------------------------------------------
    // endpoint descriptor word offsets and field positions
    // ----------------------------------------------------------------
    localparam logic [31:0] ED_OFF_W0 = 32'h0000_0000;
    localparam logic [31:0] ED_OFF_TAIL = 32'h0000_0004;
    localparam logic [31:0] ED_OFF_HEAD = 32'h0000_0008;
    localparam logic [31:0] ED_OFF_NEXT = 32'h0000_000C;
    localparam int FA_LSB = 0;
    localparam int EN_LSB = 7;
    localparam int DIR_LSB = 11;
    localparam int SPEED_BIT = 13;
    localparam int SKIP_BIT = 14;
    localparam int FMT_BIT = 15;
    localparam int MPS_LSB = 16;
    localparam int PTR_LSB = 4;
    localparam int HALT_BIT = 0;
    localparam int CARRY_BIT = 1;
    // ----------------------------------------------------------------
    // direction and packet id codes
    // ----------------------------------------------------------------
    localparam logic [1:0] DIR_OUT = 2'h1;
    localparam logic [1:0] DIR_IN = 2'h2;
    localparam logic [1:0] PID_SETUP = 2'h0;
    localparam logic [1:0] PID_OUT = 2'h1;
    localparam logic [1:0] PID_IN = 2'h2;
    // ----------------------------------------------------------------
    // interrupt event bits
    // ----------------------------------------------------------------
    localparam int NUM_EV = 4;
    localparam int EV_DONE = 0;
    localparam int EV_HALT = 1;
    localparam int EV_RETIRE = 2;
    localparam int EV_SKIP = 3;
    // ----------------------------------------------------------------
    // carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [6:0] function_address;
        logic [3:0] endpoint;
        logic [1:0] dir_code;
        logic low_speed;
        logic skip;
        logic iso_format;
        logic [10:0] max_packet_size;
        logic [27:0] queue_tail_pointer;
        logic [27:0] queue_head_pointer;
        logic carry;
        logic halted;
        logic [27:0] next_descriptor_pointer;
    } uhede_ed_t;
    typedef struct packed {
        logic [6:0] function_address;
        logic [3:0] endpoint;
        logic dir_in;
        logic is_setup;
        logic low_speed;
        logic iso_format;
        logic size_fixed;
        logic [10:0] pkt_size;
    } uhede_tok_t;
endpackage

/* verilog/uhede_ed_decode.sv */
// field decode of a fetched endpoint descriptor and the token it yields
`timescale 1ns/1ps
module uhede_ed_decode (
    input wire logic [31:0] w0,
    input wire logic [31:0] w1,
    input wire logic [31:0] w2,
    input wire logic [31:0] w3,
    input wire logic [1:0] td_pid,
    input wire logic [13:0] td_remaining,
    output uhede_pkg::uhede_ed_t ed,
    output uhede_pkg::uhede_tok_t tok
);
    logic dir_in;
    logic [10:0] out_size;

    // ----------------------------------------------------------------
    // descriptor fields
    // ----------------------------------------------------------------
    always_comb begin
        ed.function_address = w0[uhede_pkg::FA_LSB +: 7];
        ed.endpoint = w0[uhede_pkg::EN_LSB +: 4];
        ed.dir_code = w0[uhede_pkg::DIR_LSB +: 2];
        ed.low_speed = w0[uhede_pkg::SPEED_BIT]; // see RL4
        ed.skip = w0[uhede_pkg::SKIP_BIT];
        ed.iso_format = w0[uhede_pkg::FMT_BIT]; // see RL6
        ed.max_packet_size = w0[uhede_pkg::MPS_LSB +: 11];
        ed.queue_tail_pointer = w1[31:uhede_pkg::PTR_LSB];
        ed.queue_head_pointer = w2[31:uhede_pkg::PTR_LSB];
        ed.carry = w2[uhede_pkg::CARRY_BIT];
        ed.halted = w2[uhede_pkg::HALT_BIT];
        ed.next_descriptor_pointer = w3[31:uhede_pkg::PTR_LSB];
    end

    // direction: descriptor code wins unless it defers to the packet id
    always_comb begin
        if (ed.dir_code == uhede_pkg::DIR_OUT) begin // see RL3
            dir_in = 1'b0;
        end else if (ed.dir_code == uhede_pkg::DIR_IN) begin
            dir_in = 1'b1;
        end else begin
            dir_in = (td_pid == uhede_pkg::PID_IN);
        end
    end

    // outgoing packets are the smaller of max size and data left
    assign out_size = (td_remaining < {3'h0, ed.max_packet_size}) ? td_remaining[10:0] : ed.max_packet_size; // see RL7

    // token fields
    always_comb begin
        tok.function_address = ed.function_address; // see RL1
        tok.endpoint = ed.endpoint; // see RL2
        tok.dir_in = dir_in;
        tok.is_setup = (ed.dir_code != uhede_pkg::DIR_OUT) && (ed.dir_code != uhede_pkg::DIR_IN)
                       && (td_pid == uhede_pkg::PID_SETUP);
        tok.low_speed = ed.low_speed;
        tok.iso_format = ed.iso_format;
        tok.size_fixed = !dir_in; // see RL8
        tok.pkt_size = dir_in ? ed.max_packet_size : out_size; // in: only the receive limit
    end
endmodule // uhede_ed_decode

/* verilog/uhede_irq.sv */
// sticky interrupt status with enable mask and write-one clear
`timescale 1ns/1ps
module uhede_irq (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] event_set,
    input wire logic [3:0] clear,
    input wire logic [3:0] enable,
    output logic [3:0] status_q,
    output logic irq
);
    // ----------------------------------------------------------------
    // sticky bits: a new event wins over a clear in the same cycle
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status_q <= 4'h0;
        end else begin
            status_q <= (status_q & ~clear) | event_set;
        end
    end

    // level output while any enabled bit stands
    assign irq = |(status_q & enable);
endmodule // uhede_irq

/* verilog/uhede_engine.sv */
// endpoint descriptor engine: list walk, decode, token issue, write-back and apb registers
//
// Behaviour
// RL1: tokens carry the descriptor's function address as device address.
// RL2: tokens carry the descriptor's endpoint number.
// RL3: direction 01 is out, 10 is in, 00 and 11 take the packet id.
// RL4: speed bit 0 means full speed, 1 means low speed.
// RL5: skipped descriptors get no queue access and no token.
// RL6: format bit picks general (0) or isochronous (1) transfer handling.
// RL7: out and setup packets use the smaller of max size and data left.
// RL8: in packets take whatever size the endpoint returns.
// RL9: equal head and tail pointers mean an empty queue.
// RL10: a transfer ending in error sets the halted bit.
// RL11: each retire writes the last toggle into carry, except isochronous.
// RL12: head pointer names the next transfer and advances as one retires.
// RL13: nonzero next pointer is followed; zero ends the list.
// RL14: software links the tail entry before advancing the tail pointer.
// RL15: software sets skip before removing or switching a descriptor.
// RL16: only the third word holding halted, carry and head is written back.
// RL17: halted descriptors are not serviced until software clears halted.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module uhede_engine (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    output logic td_req,
    output logic [31:0] td_head_ptr,
    input wire logic td_info_valid,
    input wire logic [1:0] td_pid,
    input wire logic [13:0] td_remaining,
    output logic tok_valid,
    output uhede_pkg::uhede_tok_t tok,
    input wire logic tok_ready,
    input wire logic td_done,
    input wire logic td_error,
    input wire logic td_toggle,
    input wire logic [31:0] td_next_ptr,
    output logic irq
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_RD0, ST_RD1, ST_RD2, ST_RD3, ST_DECIDE, ST_TD_REQ, ST_TOKEN, ST_WAIT, ST_WB, ST_NEXT
    } uhede_state_t;

    uhede_state_t state_q;
    logic [31:0] w0_q;
    logic [31:0] w1_q;
    logic [31:0] w2_q;
    logic [31:0] w3_q;
    logic [31:0] ed_ptr_q;
    logic [31:0] list_head_q;
    logic [3:0] int_enable_q;
    logic [3:0] int_status;
    logic [3:0] int_clear;
    logic [3:0] events;
    logic start_pulse;
    logic err_q;
    logic [31:0] next_td_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic apb_write;
    uhede_pkg::uhede_ed_t ed;
    uhede_pkg::uhede_tok_t tok_comb;
    uhede_pkg::uhede_tok_t tok_q;

    // ----------------------------------------------------------------
    // descriptor decode and interrupt block
    // ----------------------------------------------------------------
    uhede_ed_decode u_decode (
        .w0(w0_q),
        .w1(w1_q),
        .w2(w2_q),
        .w3(w3_q),
        .td_pid(td_pid),
        .td_remaining(td_remaining),
        .ed(ed),
        .tok(tok_comb)
    );

    uhede_irq u_irq (
        .ref_clk(ref_clk),
        .rst(rst),
        .event_set(events),
        .clear(int_clear),
        .enable(int_enable_q),
        .status_q(int_status),
        .irq(irq)
    );

    // ----------------------------------------------------------------
    // apb slave: data prepared in setup, answered in the first access cycle
    // ----------------------------------------------------------------
    assign pready = psel & penable;
    assign prdata = prdata_q;
    assign pslverr = pready & pslverr_q;
    assign apb_write = psel & penable & pwrite & !pslverr_q;

    // read mux and decode, loaded in the setup cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (psel && !penable) begin
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            if (paddr == uhede_pkg::REG_CTRL) begin
                prdata_q <= 32'h0000_0000;
            end else if (paddr == uhede_pkg::REG_LIST_HEAD) begin
                prdata_q <= list_head_q;
            end else if (paddr == uhede_pkg::REG_STATE) begin
                prdata_q <= {27'h0, err_q, state_q};
            end else if (paddr == uhede_pkg::REG_INT_STATUS) begin
                prdata_q <= {28'h0, int_status};
            end else if (paddr == uhede_pkg::REG_INT_ENABLE) begin
                prdata_q <= {28'h0, int_enable_q};
            end else if (paddr == uhede_pkg::REG_INT_CLEAR) begin
                prdata_q <= 32'h0000_0000;
            end else if (paddr == uhede_pkg::REG_CUR_ED) begin
                prdata_q <= ed_ptr_q;
            end else begin
                pslverr_q <= 1'b1;
            end
        end
    end

    // software written registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            list_head_q <= uhede_pkg::RST_LIST_HEAD;
            int_enable_q <= uhede_pkg::RST_INT_ENABLE;
        end else if (apb_write) begin
            if (paddr == uhede_pkg::REG_LIST_HEAD) begin
                list_head_q <= {pwdata[31:uhede_pkg::PTR_LSB], 4'h0};
            end else if (paddr == uhede_pkg::REG_INT_ENABLE) begin
                int_enable_q <= pwdata[3:0];
            end
        end
    end

    // start strobe and write-one clear strobe
    assign start_pulse = apb_write && (paddr == uhede_pkg::REG_CTRL) && pwdata[uhede_pkg::CTRL_START_BIT];
    assign int_clear = (apb_write && (paddr == uhede_pkg::REG_INT_CLEAR)) ? pwdata[3:0] : 4'h0;

    // ----------------------------------------------------------------
    // list walk state machine
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            ed_ptr_q <= 32'h0000_0000;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start_pulse && list_head_q != 32'h0000_0000) begin
                        ed_ptr_q <= list_head_q;
                        state_q <= ST_RD0;
                    end
                end
                ST_RD0: begin
                    if (mem_ack) begin
                        state_q <= ST_RD1;
                    end
                end
                ST_RD1: begin
                    if (mem_ack) begin
                        state_q <= ST_RD2;
                    end
                end
                ST_RD2: begin
                    if (mem_ack) begin
                        state_q <= ST_RD3;
                    end
                end
                ST_RD3: begin
                    if (mem_ack) begin
                        state_q <= ST_DECIDE;
                    end
                end
                ST_DECIDE: begin
                    if (ed.skip) begin // see RL5
                        state_q <= ST_NEXT;
                    end else if (ed.halted) begin // see RL17
                        state_q <= ST_NEXT;
                    end else if (ed.queue_head_pointer == ed.queue_tail_pointer) begin // see RL9
                        state_q <= ST_NEXT;
                    end else begin
                        state_q <= ST_TD_REQ;
                    end
                end
                ST_TD_REQ: begin
                    if (td_info_valid) begin
                        state_q <= ST_TOKEN;
                    end
                end
                ST_TOKEN: begin
                    if (tok_ready) begin
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (td_done) begin
                        state_q <= ST_WB;
                    end
                end
                ST_WB: begin
                    if (mem_ack) begin
                        state_q <= ST_NEXT;
                    end
                end
                ST_NEXT: begin
                    if (ed.next_descriptor_pointer != 28'h0) begin // see RL13
                        ed_ptr_q <= {ed.next_descriptor_pointer, 4'h0};
                        state_q <= ST_RD0;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // descriptor words captured as each read completes; only fields listed are used
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            w0_q <= 32'h0000_0000;
            w1_q <= 32'h0000_0000;
            w2_q <= 32'h0000_0000;
            w3_q <= 32'h0000_0000;
        end else if (mem_ack) begin
            if (state_q == ST_RD0) begin
                w0_q <= mem_rdata;
            end else if (state_q == ST_RD1) begin
                w1_q <= mem_rdata;
            end else if (state_q == ST_RD2) begin
                w2_q <= mem_rdata;
            end else if (state_q == ST_RD3) begin
                w3_q <= mem_rdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // memory master: reads four words, writes back only the head word
    // ----------------------------------------------------------------
    assign mem_req = (state_q == ST_RD0) || (state_q == ST_RD1) || (state_q == ST_RD2)
                     || (state_q == ST_RD3) || (state_q == ST_WB);
    assign mem_we = (state_q == ST_WB); // see RL16

    // address follows the state
    always_comb begin
        if (state_q == ST_RD1) begin
            mem_addr = ed_ptr_q + uhede_pkg::ED_OFF_TAIL;
        end else if (state_q == ST_RD2 || state_q == ST_WB) begin
            mem_addr = ed_ptr_q + uhede_pkg::ED_OFF_HEAD; // see RL16
        end else if (state_q == ST_RD3) begin
            mem_addr = ed_ptr_q + uhede_pkg::ED_OFF_NEXT;
        end else begin
            mem_addr = ed_ptr_q + uhede_pkg::ED_OFF_W0;
        end
    end

    // head word rebuilt from the retired transfer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mem_wdata <= 32'h0000_0000;
        end else if (state_q == ST_WAIT && td_done) begin
            mem_wdata <= {td_next_ptr[31:uhede_pkg::PTR_LSB], w2_q[3:2],
                          ed.iso_format ? ed.carry : td_toggle, // see RL11
                          td_error | ed.halted}; // see RL10, see RL12
        end
    end

    // retire results kept for status
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            err_q <= 1'b0;
            next_td_q <= 32'h0000_0000;
        end else if (state_q == ST_WAIT && td_done) begin
            err_q <= td_error;
            next_td_q <= td_next_ptr;
        end
    end

    // ----------------------------------------------------------------
    // transfer side: head request, then token
    // ----------------------------------------------------------------
    assign td_req = (state_q == ST_TD_REQ);
    assign td_head_ptr = {w2_q[31:uhede_pkg::PTR_LSB], 4'h0}; // see RL12
    assign tok_valid = (state_q == ST_TOKEN);
    assign tok = tok_q;

    // token captured when the head transfer is described
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tok_q <= '0;
        end else if (state_q == ST_TD_REQ && td_info_valid) begin
            tok_q <= tok_comb; // see RL1, see RL2, see RL3, see RL4, see RL6, see RL7, see RL8
        end
    end

    // ----------------------------------------------------------------
    // events
    // ----------------------------------------------------------------
    always_comb begin
        events = 4'h0;
        events[uhede_pkg::EV_DONE] = (state_q == ST_NEXT) && (ed.next_descriptor_pointer == 28'h0);
        events[uhede_pkg::EV_HALT] = (state_q == ST_WAIT) && td_done && td_error;
        events[uhede_pkg::EV_RETIRE] = (state_q == ST_WAIT) && td_done;
        events[uhede_pkg::EV_SKIP] = (state_q == ST_DECIDE) && ed.skip;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_skip_no_token: assert property (@(posedge ref_clk) disable iff (rst) // see RL5
        (state_q == ST_DECIDE && ed.skip) |=> (state_q == ST_NEXT) ##1 (!tok_valid && !td_req))
        else $error("skipped descriptor was serviced");
    chk_empty_queue: assert property (@(posedge ref_clk) disable iff (rst) // see RL9
        (state_q == ST_DECIDE && !ed.skip && (ed.queue_head_pointer == ed.queue_tail_pointer)) |=> !td_req)
        else $error("empty queue was serviced");
    chk_halted_idle: assert property (@(posedge ref_clk) disable iff (rst) // see RL17
        (state_q == ST_DECIDE && ed.halted) |=> (state_q == ST_NEXT))
        else $error("halted descriptor was serviced");
    chk_token_address: assert property (@(posedge ref_clk) disable iff (rst) // see RL1
        tok_valid |-> (tok.function_address == w0_q[6:0] && tok.endpoint == w0_q[10:7]))
        else $error("token address differs from descriptor");
    chk_out_size: assert property (@(posedge ref_clk) disable iff (rst) // see RL7
        (tok_valid && !tok.dir_in) |-> (tok.pkt_size <= ed.max_packet_size && tok.size_fixed))
        else $error("out packet exceeds max packet size");
    chk_dir_decode: assert property (@(posedge ref_clk) disable iff (rst) // see RL3
        (tok_valid && ed.dir_code == uhede_pkg::DIR_IN) |-> tok.dir_in)
        else $error("in direction not honoured");
    chk_halt_on_error: assert property (@(posedge ref_clk) disable iff (rst) // see RL10
        (state_q == ST_WAIT && td_done && td_error) |=> (mem_we && mem_wdata[uhede_pkg::HALT_BIT]))
        else $error("error did not set halted");
    chk_carry_update: assert property (@(posedge ref_clk) disable iff (rst) // see RL11
        (state_q == ST_WAIT && td_done && !ed.iso_format) |=> (mem_wdata[uhede_pkg::CARRY_BIT] == $past(td_toggle)))
        else $error("toggle carry not written");
    chk_head_writeback: assert property (@(posedge ref_clk) disable iff (rst) // see RL12
        mem_we |-> (mem_addr == ed_ptr_q + uhede_pkg::ED_OFF_HEAD && mem_wdata[31:4] == next_td_q[31:4]))
        else $error("head write-back wrong");
    chk_list_end: assert property (@(posedge ref_clk) disable iff (rst) // see RL13
        (state_q == ST_NEXT && ed.next_descriptor_pointer == 28'h0) |=> (state_q == ST_IDLE) [*2])
        else $error("walk did not stop at list end");
endmodule // uhede_engine

/* testbench/uhede_mem_model.sv */
// partner model: descriptor memory and transfer side facing the engine
`timescale 1ns/1ps
module uhede_mem_model (
    input wire logic ref_clk,
    input wire logic slow,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic mem_ack = 1'b0,
    output logic [31:0] mem_rdata = 32'h0000_0000,
    input wire logic td_req,
    output logic td_info_valid = 1'b0,
    input wire logic tok_valid,
    output logic tok_ready = 1'b0,
    output logic td_done = 1'b0
);
    logic [31:0] mem [0:63];
    logic [1:0] wait_q = 2'h0;
    // memory answers after one or three cycles; released data shows the inverse
    always @(posedge ref_clk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        wait_q <= 2'h0;
        if (mem_req && !mem_ack) begin
            wait_q <= wait_q + 2'h1;
            if (wait_q == (slow ? 2'h2 : 2'h0)) begin
                mem_ack <= 1'b1;
                if (mem_we) mem[mem_addr[7:2]] <= mem_wdata;
                else mem_rdata <= mem[mem_addr[7:2]];
            end
        end
    end
    // transfer side: info, token accept, then completion one cycle later
    always @(posedge ref_clk) begin
        td_info_valid <= td_req && !td_info_valid;
        tok_ready <= tok_valid && !tok_ready;
        td_done <= tok_valid && tok_ready;
    end
endmodule // uhede_mem_model

/* testbench/test_usb_host_endpoint_descriptor_engine.sv */
// self-checking bench of the endpoint descriptor engine
`timescale 1ns/1ps
module test_usb_host_endpoint_descriptor_engine;
    logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, mem_req, mem_we, mem_ack, td_req, td_info_valid;
    logic tok_valid, tok_ready, td_done, td_error, td_toggle, irq, slow, last_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, td_head_ptr, rd;
    logic [1:0] td_pid;
    uhede_pkg::uhede_tok_t tok, tok_seen;
    int miscompares = 0, samples_checked = 0, tok_cnt = 0, cycles = 0;
    uhede_engine i_uhede_engine (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .td_req(td_req), .td_head_ptr(td_head_ptr), .td_info_valid(td_info_valid), .td_pid(td_pid),
        .td_remaining(14'h0005), .tok_valid(tok_valid), .tok(tok), .tok_ready(tok_ready), .td_done(td_done),
        .td_error(td_error), .td_toggle(td_toggle), .td_next_ptr(32'h0000_0200), .irq(irq));
    uhede_mem_model i_uhede_mem_model (.ref_clk(ref_clk), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .td_req(td_req),
        .td_info_valid(td_info_valid), .tok_valid(tok_valid), .tok_ready(tok_ready), .td_done(td_done));
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // apb transfer: setup, then access held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // one walk: descriptor at 0x40, serviced unless halted or empty, linked to a skipped one at 0x80
    task automatic run(input logic [31:0] w0, w2, input logic [3:0] td, input logic [31:0] xw2,
        input logic [26:0] xt, input int xn);
        i_uhede_mem_model.mem[16] = w0; i_uhede_mem_model.mem[17] = 32'h300;
        i_uhede_mem_model.mem[18] = w2; i_uhede_mem_model.mem[19] = 32'h80;
        i_uhede_mem_model.mem[32] = 32'h4000; i_uhede_mem_model.mem[33] = 32'h300;
        i_uhede_mem_model.mem[34] = 32'h100; i_uhede_mem_model.mem[35] = 32'h0;
        {td_error, td_toggle, td_pid} <= td;
        tok_cnt = 0;
        apb(1'b1, uhede_pkg::REG_INT_CLEAR, 32'hF);
        apb(1'b1, uhede_pkg::REG_CTRL, 32'h1);
        do apb(1'b0, uhede_pkg::REG_INT_STATUS, 32'h0); while (rd[0] !== 1'b1);
        check(i_uhede_mem_model.mem[18], xw2);
        check(i_uhede_mem_model.mem[34], 32'h100);
        check(tok_cnt, xn);
        if (xn > 0) check(32'(tok_seen), 32'(xt));
    endtask
    // ----------------------------------------------------------------
    // clock, timeout, token capture and main sequence
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (td_req && td_info_valid) check(td_head_ptr, 32'h100);
        if (tok_valid && tok_ready) begin
            tok_seen = tok;
            tok_cnt++;
        end
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish;
        end
    end
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata, td_pid, td_error, td_toggle, slow} = '0;
        rst = 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b0, uhede_pkg::REG_LIST_HEAD, 32'h0);
        check(rd, uhede_pkg::RST_LIST_HEAD);
        apb(1'b0, 8'h1C, 32'h0);
        check({31'h0, last_err}, 32'h1);
        apb(1'b1, uhede_pkg::REG_INT_ENABLE, 32'hF);
        apb(1'b1, uhede_pkg::REG_LIST_HEAD, 32'h40);
        run(32'h0003_09DA, 32'h100, 4'h5, 32'h202, {7'h5A, 4'h3, 5'h01, 11'h003}, 1);
        check({31'h0, irq}, 32'h1);
        apb(1'b0, uhede_pkg::REG_INT_STATUS, 32'h0);
        check(rd, 32'hD);
        apb(1'b1, uhede_pkg::REG_INT_CLEAR, 32'hF);
        @(posedge ref_clk);
        check({31'h0, irq}, 32'h0);
        run(32'h03FF_3FFF, 32'h100, 4'h8, 32'h201, {7'h7F, 4'hF, 5'h0D, 11'h005}, 1);
        slow <= 1'b1;
        run(32'h0010_9081, 32'h100, 4'h6, 32'h200, {7'h01, 4'h1, 5'h12, 11'h010}, 1);
        run(32'h0003_09DA, 32'h101, 4'h5, 32'h101, 27'h0, 0);
        run(32'h0003_09DA, 32'h300, 4'h5, 32'h300, 27'h0, 0);
        tally_and_finish;
    end
endmodule // test_usb_host_endpoint_descriptor_engine
